// >>> hw/pmic_event_pkg.sv
// shared constants, types and event attribute masks of the event/status block
package pmic_event_pkg;

    // event bit positions inside the status vector
    localparam int EVENT_COUNT = 22;
    localparam int EV_BULK_OV = 0;
    localparam int EV_RAILA_PG = 1;
    localparam int EV_RAILB_PG = 2;
    localparam int EV_RAILC_PG = 3;
    localparam int EV_LDO1V8_PG = 4;
    localparam int EV_LDO1V0_PG = 5;
    localparam int EV_RAILA_OV = 6;
    localparam int EV_RAILB_OV = 7;
    localparam int EV_RAILC_OV = 8;
    localparam int EV_RAILA_UV = 9;
    localparam int EV_RAILB_UV = 10;
    localparam int EV_RAILC_UV = 11;
    localparam int EV_RAILA_ILIM = 12;
    localparam int EV_RAILB_ILIM = 13;
    localparam int EV_RAILC_ILIM = 14;
    localparam int EV_RAILA_HICUR = 15;
    localparam int EV_RAILB_HICUR = 16;
    localparam int EV_RAILC_HICUR = 17;
    localparam int EV_HIGH_TEMP = 18;
    localparam int EV_CRIT_TEMP = 19;
    localparam int EV_PEC_ERR = 20;
    localparam int EV_PARITY_ERR = 21;

    // events that make the device shut its regulators down
    localparam logic [EVENT_COUNT-1:0] EV_SHUTDOWN = 22'h080FC1;
    // rail power-good events: pull power-good low without shutdown
    localparam logic [EVENT_COUNT-1:0] EV_RAILPG = 22'h00003E;
    // every event except critical temperature has a clear and a mask bit
    localparam logic [EVENT_COUNT-1:0] EV_CLEARABLE = 22'h37FFFF;
    localparam logic [EVENT_COUNT-1:0] EV_STATUS_RESET = 22'h000000;

    // power-good mode field
    localparam logic [1:0] PGMODE_MASK_BOTH = 2'h0;
    localparam logic [1:0] PGMODE_IRQ_ONLY = 2'h1;
    localparam logic [1:0] PGMODE_SHUT_ONLY = 2'h2;

    typedef enum logic [2:0] {
        STATE_INPUT_INVALID = 3'b000,
        STATE_QUIESCENT = 3'b001,
        STATE_STANDBY_INITIAL = 3'b010,
        STATE_STANDBY_NO_FAULT = 3'b011,
        STATE_STANDBY_FAULT = 3'b100,
        STATE_REGULATION = 3'b101
    } power_state_e;

    // host configuration bits
    typedef struct packed {
        logic quiescentEnable;
        logic irqEnable;
        logic [1:0] pgMode;
    } host_ctrl_s;

    // regulator and interface status seen by the rest of the chip
    typedef struct packed {
        logic bucksOn;
        logic ldosOn;
        logic busAccessOk;
        logic regEnableBit;
    } reg_status_s;

    localparam reg_status_s REG_STATUS_RESET = 4'h0;

endpackage : pmic_event_pkg

// >>> hw/pin_sync.sv
// two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // levels
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);
    logic [WIDTH-1:0] stage1;

    // stage1 feeds only the second flop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            stage1 <= '0;
            syncOut <= '0;
        end else begin
            stage1 <= asyncIn;
            syncOut <= stage1;
        end
    end
endmodule : pin_sync
`default_nettype wire

// >>> hw/sticky_status.sv
// vector of sticky status bits, set by events and cleared by host pulses
`timescale 1ns/1ns
`default_nettype none
module sticky_status
    import pmic_event_pkg::*;
#(
    parameter int WIDTH = EVENT_COUNT,
    parameter logic [WIDTH-1:0] CLEARABLE = '1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // event levels and clear pulses
    input wire logic [WIDTH-1:0] setVec,
    input wire logic [WIDTH-1:0] clearVec,
    // latched status
    output logic [WIDTH-1:0] status
);
    logic [WIDTH-1:0] next_status;

    // a present event wins over a clear in the same cycle
    always_comb begin
        next_status = setVec | (status & ~(clearVec & CLEARABLE));
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            status <= RESET_VALUE;
        end else begin
            status <= next_status;
        end
    end
endmodule : sticky_status
`default_nettype wire

// >>> hw/pmic_event_status_interrupt.sv
// power state tracking, event latching, interrupt and power-good outputs
//
// Summary of operation
// - quiescent state turns every regulator off and refuses bus access; needs quiescent enable
// - with quiescent enable clear, enable pin fall goes to no-fault standby with bus access kept
// - quiescent is entered only from regulation and only with quiescent enable set
// - after a fault shutdown bucks stay off, ldos on, power-good low, enable bit zero
// - standby after power-up or quiescent: bucks off, ldos on, power-good low, bit zero
// - regulation turns all bucks on and reads the enable bit as one
// - interrupt pin is open-drain and stays released until the host enables it
// - an unmasked event pulls the interrupt low and sets power-good per event
// - events without shutdown leave the power state untouched
// - bulk input over-voltage latches, requests shutdown and pulls power-good low
// - buck rail power-good loss latches, pulls power-good low, raises interrupt, no shutdown
// - 1.0 V ldo power-good loss latches and pulls power-good low, no shutdown
// - buck over or under voltage latches, requests shutdown and pulls power-good low
// - current, power and warm temperature events raise only the interrupt
// - critical temperature is unclearable, unmaskable, shuts down until power cycle
// - packet check and parity errors latch and raise only the interrupt
// - interrupt and power-good stay asserted until the host clears or masks
// - after clear the interrupt releases; power-good waits for re-enable on shutdown events
// - masked with mode 00: no interrupt, rail power-good events still pull low
// - mode 01 keeps interrupts but frees power-good; mode 10 only shutdown holds it
// - a mask only suppresses output assertion, never the latching or shutdown
// - an internal shutdown request drops power-good and starts the power-off sequence
`timescale 1ns/1ns
`default_nettype none
module pmic_event_status_interrupt
    import pmic_event_pkg::*;
#(
    parameter int NUM_EVENTS = EVENT_COUNT
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // pins and analogue monitors, asynchronous
    input wire logic bulkInputSupplyOk,
    input wire logic regulatorEnableIn,
    input wire logic [NUM_EVENTS-1:0] eventIn,
    // host side configuration and commands, same clock
    input wire host_ctrl_s hostCtrl,
    input wire logic [NUM_EVENTS-1:0] eventMask,
    input wire logic [NUM_EVENTS-1:0] eventClear,
    input wire logic enableCmd,
    input wire logic disableCmd,
    // open-drain interrupt pin
    input wire logic statusIrqInN,
    output logic statusIrqOutN,
    output logic statusIrqOe,
    // power-good and regulator control
    output logic supplyOkOut,
    output logic regulatorShutdownRequest,
    output reg_status_s regStatus,
    // readable state
    output power_state_e powerState,
    output logic [NUM_EVENTS-1:0] eventStatus
);
    logic [NUM_EVENTS+1:0] pinSync;
    logic [NUM_EVENTS-1:0] evSync;
    logic bulkOk;
    logic enPin;
    logic enPinPrev;
    logic next_enPinPrev;

    pin_sync #(
        .WIDTH(NUM_EVENTS + 2)
    ) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .asyncIn({regulatorEnableIn, bulkInputSupplyOk, eventIn}),
        .syncOut(pinSync)
    );

    assign evSync = pinSync[NUM_EVENTS-1:0];
    assign bulkOk = pinSync[NUM_EVENTS];
    assign enPin = pinSync[NUM_EVENTS+1];

    // status bits latch whether masked or not
    sticky_status #(
        .WIDTH(NUM_EVENTS),
        .CLEARABLE(EV_CLEARABLE),
        .RESET_VALUE(EV_STATUS_RESET)
    ) u_status (
        .clk(clk),
        .sys_rst(sys_rst),
        .setVec(evSync),
        .clearVec(eventClear),
        .status(eventStatus)
    );

    // power state machine
    power_state_e state;
    power_state_e next_state;
    logic shutActive;
    logic critLatched;
    logic enRise;
    logic enFall;

    always_comb begin
        next_enPinPrev = enPin;
        shutActive = |(eventStatus & EV_SHUTDOWN);
        critLatched = eventStatus[EV_CRIT_TEMP];
        enRise = enPin && !enPinPrev;
        enFall = !enPin && enPinPrev;
        next_state = state;
        if (!bulkOk) begin
            next_state = STATE_INPUT_INVALID;
        end else begin
            case (state)
                STATE_INPUT_INVALID: begin
                    next_state = STATE_STANDBY_INITIAL;
                end
                STATE_QUIESCENT: begin
                    if (enRise) begin
                        next_state = STATE_STANDBY_INITIAL;
                    end
                end
                STATE_STANDBY_INITIAL: begin
                    if ((enPin || enableCmd) && !shutActive) begin
                        next_state = STATE_REGULATION;
                    end
                end
                STATE_STANDBY_NO_FAULT: begin
                    if ((enRise || enableCmd) && !shutActive) begin
                        next_state = STATE_REGULATION;
                    end
                end
                STATE_STANDBY_FAULT: begin
                    // critical temperature holds here until reset
                    if ((enRise || enableCmd) && !shutActive && !critLatched) begin
                        next_state = STATE_REGULATION;
                    end
                end
                STATE_REGULATION: begin
                    // shutdown events win; enable pin fall or disable command also leave regulation
                    if (shutActive) begin
                        next_state = STATE_STANDBY_FAULT;
                    end else if (enFall && hostCtrl.quiescentEnable) begin
                        next_state = STATE_QUIESCENT;
                    end else if (enFall || disableCmd) begin
                        next_state = STATE_STANDBY_NO_FAULT;
                    end
                end
                default: begin
                    next_state = STATE_INPUT_INVALID;
                end
            endcase
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= STATE_INPUT_INVALID;
            enPinPrev <= 1'b0;
        end else begin
            state <= next_state;
            enPinPrev <= next_enPinPrev;
        end
    end

    // output stage, the state-derived outputs follow next_state so they line up with state
    logic [NUM_EVENTS-1:0] irqSrc;
    logic [NUM_EVENTS-1:0] pgSrc;
    logic [NUM_EVENTS-1:0] railMaskEff;
    logic next_irqOe;
    logic next_supplyOk;
    logic next_shutReq;
    reg_status_s next_regStatus;

    always_comb begin
        // mode 01 lets masked events still pull the interrupt
        if (hostCtrl.pgMode == PGMODE_IRQ_ONLY) begin
            irqSrc = eventStatus;
        end else begin
            irqSrc = eventStatus & (~eventMask | ~EV_CLEARABLE);
        end
        // mode 00 keeps rail power-good events on the pin despite masks
        if (hostCtrl.pgMode == PGMODE_MASK_BOTH) begin
            railMaskEff = '0;
        end else begin
            railMaskEff = eventMask;
        end
        pgSrc = eventStatus & (EV_SHUTDOWN | (EV_RAILPG & ~railMaskEff));
        next_irqOe = hostCtrl.irqEnable && (|irqSrc);
        next_supplyOk = (next_state == STATE_REGULATION) && !(|pgSrc);
        next_shutReq = (state == STATE_REGULATION) && (next_state == STATE_STANDBY_FAULT);
        next_regStatus.bucksOn = (next_state == STATE_REGULATION);
        next_regStatus.regEnableBit = (next_state == STATE_REGULATION);
        next_regStatus.ldosOn = (next_state != STATE_QUIESCENT) && (next_state != STATE_INPUT_INVALID);
        next_regStatus.busAccessOk = (next_state != STATE_QUIESCENT);
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            statusIrqOe <= 1'b0;
            statusIrqOutN <= 1'b0;
            supplyOkOut <= 1'b0;
            regulatorShutdownRequest <= 1'b0;
            regStatus <= REG_STATUS_RESET;
            powerState <= STATE_INPUT_INVALID;
        end else begin
            statusIrqOe <= next_irqOe;
            // open-drain: only ever drives low
            statusIrqOutN <= 1'b0;
            supplyOkOut <= next_supplyOk;
            regulatorShutdownRequest <= next_shutReq;
            regStatus <= next_regStatus;
            powerState <= next_state;
        end
    end

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_quiescent_off;
        state == STATE_QUIESCENT |-> !regStatus.bucksOn && !regStatus.ldosOn && !regStatus.busAccessOk;
    endproperty
    a_quiescent_off: assert property (p_quiescent_off) else $error("quiescent leaves a rail or bus on");

    property p_quiescent_entry;
        $changed(state) && state == STATE_QUIESCENT |->
            $past(state) == STATE_REGULATION && $past(hostCtrl.quiescentEnable);
    endproperty
    a_quiescent_entry: assert property (p_quiescent_entry) else $error("bad quiescent entry");

    property p_fault_standby;
        state == STATE_STANDBY_FAULT |-> !supplyOkOut && !regStatus.bucksOn && regStatus.ldosOn
            && !regStatus.regEnableBit;
    endproperty
    a_fault_standby: assert property (p_fault_standby) else $error("fault standby outputs wrong");

    property p_initial_standby;
        state == STATE_STANDBY_INITIAL |-> !supplyOkOut && !regStatus.bucksOn && regStatus.ldosOn
            && !regStatus.regEnableBit;
    endproperty
    a_initial_standby: assert property (p_initial_standby) else $error("initial standby outputs wrong");

    property p_regulation_on;
        state == STATE_REGULATION |-> regStatus.bucksOn && regStatus.regEnableBit;
    endproperty
    a_regulation_on: assert property (p_regulation_on) else $error("regulation without bucks on");

    property p_irq_gate;
        !hostCtrl.irqEnable |=> !statusIrqOe && !statusIrqOutN;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("interrupt driven while disabled");

    property p_irq_unmasked;
        hostCtrl.irqEnable && (|(eventStatus & ~eventMask)) |=> statusIrqOe;
    endproperty
    a_irq_unmasked: assert property (p_irq_unmasked) else $error("unmasked event gave no interrupt");

    property p_shutdown;
        bulkOk && state == STATE_REGULATION && (|(eventStatus & EV_SHUTDOWN)) |=>
            state == STATE_STANDBY_FAULT && regulatorShutdownRequest ##1 !regulatorShutdownRequest;
    endproperty
    a_shutdown: assert property (p_shutdown) else $error("shutdown event did not shut down");

    property p_no_shutdown;
        bulkOk && state == STATE_REGULATION && !(|(eventStatus & EV_SHUTDOWN)) && !enFall && !disableCmd
            |=> state == STATE_REGULATION;
    endproperty
    a_no_shutdown: assert property (p_no_shutdown) else $error("non-shutdown event left regulation");

    property p_crit_hold;
        state == STATE_STANDBY_FAULT && eventStatus[EV_CRIT_TEMP] |=> state != STATE_REGULATION && !supplyOkOut;
    endproperty
    a_crit_hold: assert property (p_crit_hold) else $error("recovered from critical temperature");

    property p_sticky;
        1'b1 |=> ((($past(eventStatus) & ~($past(eventClear) & EV_CLEARABLE)) & ~eventStatus) == '0);
    endproperty
    a_sticky: assert property (p_sticky) else $error("status bit dropped without clear");

    property p_clear;
        1'b1 |=> ((eventStatus & $past(eventClear & EV_CLEARABLE & ~evSync)) == '0);
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not reset status bit");

    property p_railpg_low;
        (|(eventStatus & EV_RAILPG & ~eventMask)) |=> !supplyOkOut;
    endproperty
    a_railpg_low: assert property (p_railpg_low) else $error("rail event left power-good high");

    // warnings alone must never cost the host its power-good
    property p_warn_pg_high;
        bulkOk && state == STATE_REGULATION && !enFall && !disableCmd
            && !(|(eventStatus & (EV_SHUTDOWN | EV_RAILPG))) |=> supplyOkOut;
    endproperty
    a_warn_pg_high: assert property (p_warn_pg_high) else $error("warning event dropped power-good");

    property p_mode01_irq;
        hostCtrl.irqEnable && hostCtrl.pgMode == PGMODE_IRQ_ONLY && (|eventStatus) |=> statusIrqOe;
    endproperty
    a_mode01_irq: assert property (p_mode01_irq) else $error("mode 01 event gave no interrupt");

    property p_masked_quiet;
        (hostCtrl.pgMode == PGMODE_MASK_BOTH || hostCtrl.pgMode == PGMODE_SHUT_ONLY)
            && !(|(eventStatus & (~eventMask | ~EV_CLEARABLE))) |=> !statusIrqOe;
    endproperty
    a_masked_quiet: assert property (p_masked_quiet) else $error("masked event raised the interrupt");

    c_fault: cover property (state == STATE_REGULATION ##1 state == STATE_STANDBY_FAULT);
    c_quiescent: cover property (state == STATE_REGULATION ##1 state == STATE_QUIESCENT);
    c_irq_set: cover property ($rose(statusIrqOe));
    c_irq_release: cover property ($fell(statusIrqOe) && state == STATE_REGULATION);
    c_pin_low: cover property (statusIrqOe && !statusIrqInN);

endmodule : pmic_event_status_interrupt
`default_nettype wire

// >>> test/host_sideband_model.sv
// host-side model: interrupt pull-up and a status service routine
`timescale 1ns/1ns
`default_nettype none
module host_sideband_model
    import pmic_event_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // device side
    input wire logic irqOe,
    input wire logic [EVENT_COUNT-1:0] statusIn,
    input wire logic serviceEn,
    // host side
    output logic irqPinN,
    output logic [EVENT_COUNT-1:0] clearReq
);
    logic [EVENT_COUNT-1:0] next_clearReq;
    // pull-up resistor: a released pin reads high
    assign irqPinN = irqOe ? 1'b0 : 1'b1;
    // clears go out every other cycle so each write is a single pulse
    always_comb begin
        next_clearReq = '0;
        if (serviceEn && !irqPinN && clearReq == '0) begin
            next_clearReq = statusIn & EV_CLEARABLE;
        end
    end
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            clearReq <= '0;
        end else begin
            clearReq <= next_clearReq;
        end
    end
endmodule : host_sideband_model
`default_nettype wire

// >>> test/pmic_event_status_interrupt_tb.sv
// self-checking bench of the event, interrupt and power-good block
`timescale 1ns/1ns
`default_nettype none
module pmic_event_status_interrupt_tb
    import pmic_event_pkg::*;
;
    logic clk = 1'b0;
    logic sysRst = 1'b1;
    logic bulkOk = 1'b1;
    logic vrPin = 1'b0;
    logic [EVENT_COUNT-1:0] eventIn = '0;
    host_ctrl_s hostCtrl = '0;
    logic [EVENT_COUNT-1:0] eventMask = '0;
    logic [EVENT_COUNT-1:0] benchClear = '0;
    logic enableCmd = 1'b0;
    logic disableCmd = 1'b0;
    logic serviceEn = 1'b0;
    logic irqPinN, statusIrqOutN, statusIrqOe, supplyOkOut, regulatorShutdownRequest;
    logic [EVENT_COUNT-1:0] clearReq, eventStatus;
    reg_status_s regStatus;
    power_state_e powerState;
    int n_mismatch = 0;
    int samples_checked = 0;

    always #10 clk = ~clk;

    host_sideband_model host_u (.clk(clk), .sys_rst(sysRst), .irqOe(statusIrqOe), .statusIn(eventStatus),
        .serviceEn(serviceEn), .irqPinN(irqPinN), .clearReq(clearReq));

    pmic_event_status_interrupt dut_u (.clk(clk), .sys_rst(sysRst), .bulkInputSupplyOk(bulkOk),
        .regulatorEnableIn(vrPin), .eventIn(eventIn), .hostCtrl(hostCtrl), .eventMask(eventMask),
        .eventClear(benchClear | clearReq), .enableCmd(enableCmd), .disableCmd(disableCmd),
        .statusIrqInN(irqPinN), .statusIrqOutN(statusIrqOutN), .statusIrqOe(statusIrqOe),
        .supplyOkOut(supplyOkOut), .regulatorShutdownRequest(regulatorShutdownRequest),
        .regStatus(regStatus), .powerState(powerState), .eventStatus(eventStatus));

    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : summarize

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : tick

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error %s expected %0h seen %0h", name, exp, got);
            n_mismatch++;
        end
    endtask : check

    task automatic timeout();
        $display("Error wait expected completion seen timeout");
        n_mismatch++;
        summarize();
    endtask : timeout

    task automatic waitState(input power_state_e s);
        for (int k = 0; k < 20; k++) begin
            if (powerState === s) break;
            tick(1);
        end
        if (powerState !== s) timeout();
    endtask : waitState

    task automatic clearBits(input logic [EVENT_COUNT-1:0] bits);
        benchClear = bits;
        tick(1);
        benchClear = '0;
    endtask : clearBits

    task automatic enable();
        enableCmd = 1'b1;
        tick(1);
        enableCmd = 1'b0;
    endtask : enable

    task automatic hitEvent(input int b, input logic expOe, input logic expOk);
        eventIn[b] = 1'b1;
        tick(5);
        check("eventStatus bit", 32'(eventStatus[b]), 32'h1);
        check("statusIrqOe", 32'(statusIrqOe), 32'(expOe));
        check("supplyOkOut", 32'(supplyOkOut), 32'(expOk));
        check("powerState", 32'(powerState), 32'(STATE_REGULATION));
        eventIn[b] = 1'b0;
        tick(3);
        clearBits(EVENT_COUNT'(1) << b);
        check("cleared bit", 32'(eventStatus[b]), 32'h0);
        tick(2);
        check("released irq", 32'(irqPinN), 32'h1);
        check("supplyOkOut after clear", 32'(supplyOkOut), 32'h1);
    endtask : hitEvent

    task automatic sc_powerup();
        waitState(STATE_STANDBY_INITIAL);
        check("bucksOn", 32'(regStatus.bucksOn), 32'h0);
        check("ldosOn", 32'(regStatus.ldosOn), 32'h1);
        check("regEnableBit", 32'(regStatus.regEnableBit), 32'h0);
        check("supplyOkOut", 32'(supplyOkOut), 32'h0);
        check("statusIrqOe", 32'(statusIrqOe), 32'h0);
        enable();
        waitState(STATE_REGULATION);
        check("bucksOn", 32'(regStatus.bucksOn), 32'h1);
        check("regEnableBit", 32'(regStatus.regEnableBit), 32'h1);
        check("busAccessOk", 32'(regStatus.busAccessOk), 32'h1);
    endtask : sc_powerup

    task automatic sc_irqGate();
        eventIn[EV_RAILA_ILIM] = 1'b1;
        tick(5);
        check("disabled irq", 32'(irqPinN), 32'h1);
        hostCtrl.irqEnable = 1'b1;
        tick(2);
        check("enabled irq", 32'(irqPinN), 32'h0);
        check("open-drain data", 32'(statusIrqOutN), 32'h0);
        clearBits(EVENT_COUNT'(1) << EV_RAILA_ILIM);
        tick(10);
        check("status while present", 32'(eventStatus[EV_RAILA_ILIM]), 32'h1);
        check("irq held", 32'(statusIrqOe), 32'h1);
        eventIn[EV_RAILA_ILIM] = 1'b0;
        tick(8);
        check("irq held after event gone", 32'(statusIrqOe), 32'h1);
        clearBits(EVENT_COUNT'(1) << EV_RAILA_ILIM);
        tick(1);
        check("irq after clear", 32'(statusIrqOe), 32'h0);
    endtask : sc_irqGate

    task automatic sc_warnEvents();
        int bits[9] = '{EV_RAILA_ILIM, EV_RAILB_ILIM, EV_RAILC_ILIM, EV_RAILA_HICUR, EV_RAILB_HICUR,
            EV_RAILC_HICUR, EV_HIGH_TEMP, EV_PEC_ERR, EV_PARITY_ERR};
        foreach (bits[i]) hitEvent(bits[i], 1'b1, 1'b1);
    endtask : sc_warnEvents

    task automatic sc_railPg();
        int k;
        serviceEn = 1'b1;
        for (int b = EV_RAILA_PG; b <= EV_LDO1V0_PG; b++) begin
            eventIn[b] = 1'b1;
            tick(8);
            check("rail pg status", 32'(eventStatus[b]), 32'h1);
            check("rail pg supplyOk", 32'(supplyOkOut), 32'h0);
            check("rail pg irq", 32'(statusIrqOe), 32'h1);
            check("no shutdown", 32'(powerState), 32'(STATE_REGULATION));
            eventIn[b] = 1'b0;
            for (k = 0; k < 12 && supplyOkOut !== 1'b1; k++) tick(1);
            if (k == 12) timeout();
            tick(1);
            check("serviced irq", 32'(statusIrqOe), 32'h0);
        end
        serviceEn = 1'b0;
    endtask : sc_railPg

    task automatic sc_maskModes();
        eventMask = '1;
        for (int m = 0; m < 3; m++) begin
            hostCtrl.pgMode = 2'(m);
            hitEvent(EV_RAILA_PG, 1'(m == 1), 1'(m != 0));
            hitEvent(EV_RAILA_ILIM, 1'(m == 1), 1'b1);
        end
        eventMask = '0;
        hostCtrl.pgMode = PGMODE_MASK_BOTH;
    endtask : sc_maskModes

    task automatic sc_fault(input int b, input logic masked);
        int k;
        eventMask = masked ? '1 : '0;
        eventIn[b] = 1'b1;
        for (k = 0; k < 12 && regulatorShutdownRequest !== 1'b1; k++) tick(1);
        if (k == 12) timeout();
        check("fault state", 32'(powerState), 32'(STATE_STANDBY_FAULT));
        check("fault supplyOk", 32'(supplyOkOut), 32'h0);
        check("fault bucks", 32'({regStatus.bucksOn, regStatus.ldosOn, regStatus.regEnableBit}), 32'h2);
        tick(1);
        check("request pulse", 32'(regulatorShutdownRequest), 32'h0);
        enable();
        tick(3);
        check("enable refused", 32'(powerState), 32'(STATE_STANDBY_FAULT));
        eventIn[b] = 1'b0;
        tick(3);
        clearBits('1);
        enable();
        waitState(STATE_REGULATION);
        tick(1);
        check("re-enabled supplyOk", 32'(supplyOkOut), 32'h1);
        eventMask = '0;
    endtask : sc_fault

    task automatic sc_quiescent();
        hostCtrl.quiescentEnable = 1'b1;
        vrPin = 1'b1;
        tick(4);
        vrPin = 1'b0;
        waitState(STATE_QUIESCENT);
        check("quiescent rails", 32'({regStatus.bucksOn, regStatus.ldosOn}), 32'h0);
        check("quiescent bus", 32'(regStatus.busAccessOk), 32'h0);
        vrPin = 1'b1;
        waitState(STATE_REGULATION);
        hostCtrl.quiescentEnable = 1'b0;
        vrPin = 1'b0;
        waitState(STATE_STANDBY_NO_FAULT);
        check("idle bus", 32'(regStatus.busAccessOk), 32'h1);
        hostCtrl.quiescentEnable = 1'b1;
        tick(4);
        check("no quiescent from standby", 32'(powerState), 32'(STATE_STANDBY_NO_FAULT));
        hostCtrl.quiescentEnable = 1'b0;
        enable();
        waitState(STATE_REGULATION);
        disableCmd = 1'b1;
        tick(1);
        disableCmd = 1'b0;
        waitState(STATE_STANDBY_NO_FAULT);
        enable();
        waitState(STATE_REGULATION);
    endtask : sc_quiescent

    task automatic sc_bulkLoss();
        bulkOk = 1'b0;
        waitState(STATE_INPUT_INVALID);
        check("invalid supplyOk", 32'(supplyOkOut), 32'h0);
        bulkOk = 1'b1;
        waitState(STATE_STANDBY_INITIAL);
        check("reentry supplyOk", 32'(supplyOkOut), 32'h0);
        check("reentry bucks", 32'({regStatus.bucksOn, regStatus.ldosOn, regStatus.regEnableBit}), 32'h2);
        enable();
        waitState(STATE_REGULATION);
    endtask : sc_bulkLoss

    task automatic sc_critTemp();
        eventMask = '1;
        eventIn[EV_CRIT_TEMP] = 1'b1;
        tick(6);
        check("crit state", 32'(powerState), 32'(STATE_STANDBY_FAULT));
        check("crit irq unmaskable", 32'(statusIrqOe), 32'h1);
        check("crit supplyOk", 32'(supplyOkOut), 32'h0);
        eventIn[EV_CRIT_TEMP] = 1'b0;
        tick(3);
        clearBits('1);
        enable();
        tick(4);
        check("crit sticky", 32'(eventStatus[EV_CRIT_TEMP]), 32'h1);
        check("crit no recovery", 32'(powerState), 32'(STATE_STANDBY_FAULT));
        sysRst = 1'b1;
        tick(2);
        sysRst = 1'b0;
        tick(1);
        check("power cycle status", 32'(eventStatus), 32'h0);
    endtask : sc_critTemp

    initial begin
        repeat (3) @(posedge clk);
        #2;
        sysRst = 1'b0;
        sc_powerup();
        sc_irqGate();
        sc_warnEvents();
        sc_railPg();
        sc_maskModes();
        sc_fault(EV_BULK_OV, 1'b0);
        sc_fault(EV_RAILA_OV, 1'b0);
        sc_fault(EV_RAILA_UV, 1'b1);
        sc_quiescent();
        sc_bulkLoss();
        sc_critTemp();
        summarize();
    end
endmodule : pmic_event_status_interrupt_tb
`default_nettype wire
